// >>> rtl/jrc_top.sv
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`include "jrc_defs.svh"

// What this block does
// - Request high: returned clock held low
// - Request low: test clock sent back
// - Returned clock feeds next device's clock
// - Config mode: FPGAs in chain, TAP out
// - System reset active low, open collector
// - Config mode: system reset drives FPGA init
// - Test reset asserted at power-up, open collector
// - Config mode: test reset drives FPGA program
// - Acknowledge debug once core in debug
// - Debug mode: shared done line holds system reset
// - Jumper select level chooses JTAG path
// - Debug mode: analyzer on, base FPGA out
// - Config mode: analyzer off, base FPGA in
// - Debug mode: signals through chip TAP
module jrc_top (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Link clock
  input wire logic tck_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode select and return clock
  input wire logic config_mode_select_n_i,
  input wire logic return_clock_request_n_i,
  output logic returned_test_clock_o,
  // Open-collector lines
  input wire logic system_reset_n_i,
  output logic system_reset_n_o,
  output logic system_reset_n_oe_o,
  input wire logic test_reset_n_i,
  output logic test_reset_n_o,
  output logic test_reset_n_oe_o,
  input wire logic global_done_i,
  output logic global_done_o,
  output logic global_done_oe_o,
  input wire logic local_fpga_done_i,
  // FPGA configuration controls
  output logic fpga_init_n_o,
  output logic fpga_program_n_o,
  // Debug handshake
  input wire logic debug_request_i,
  output logic debug_acknowledge_o,
  output logic core_debug_request_o,
  input wire logic core_in_debug_i,
  // Scan path
  input wire logic dbg_chain_tdo_i,
  input wire logic cfg_chain_tdo_i,
  output logic chain_tdo_o,
  output logic chip_tap_sel_o,
  output logic fpgas_in_chain_o,
  output logic la_connector_en_o,
  output logic base_fpga_in_cfg_chain_o
);

  // ***********************************
  // Pin synchronisers
  // ***********************************
  logic [`JRC_NSYNC-1:0] pin_w;
  logic [`JRC_NSYNC-1:0] sync1_r;
  logic [`JRC_NSYNC-1:0] sync2_r;

  assign pin_w = {return_clock_request_n_i, debug_request_i, global_done_i,
                  test_reset_n_i, system_reset_n_i, config_mode_select_n_i};

  // A literal cannot be bit-selected, so the reset pattern lives in a constant
  localparam logic [`JRC_NSYNC-1:0] SYNC_RST = `JRC_SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `JRC_NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          sync1_r[gi] <= SYNC_RST[gi];
          sync2_r[gi] <= SYNC_RST[gi];
        end
        else
        begin
          sync1_r[gi] <= pin_w[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // ***********************************
  // Power-up sequence and mode latch
  // ***********************************
  jrc_pkg::jrc_state_t state_r;
  logic [`JRC_POR_W-1:0] por_cnt_r;
  logic cfg_mode_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= jrc_pkg::st_por;
      por_cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        jrc_pkg::st_por:
        begin
          por_cnt_r <= por_cnt_r + 1'b1;
          if (por_cnt_r == `JRC_POR_W'(`JRC_POR_CYC - 1))
            state_r <= jrc_pkg::st_latch;
        end
        jrc_pkg::st_latch: state_r <= jrc_pkg::st_run;
        jrc_pkg::st_run: state_r <= jrc_pkg::st_run;
        default: state_r <= jrc_pkg::st_por;
      endcase
    end
  end

  // Sampled once so a jumper moved mid-configuration cannot reroute the chain
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_mode_r <= 1'b0;
    else if (state_r == jrc_pkg::st_latch)
      cfg_mode_r <= ~sync2_r[`JRC_S_CFG];
  end

  // ***********************************
  // Wishbone register file
  // ***********************************
  logic [`JRC_CTRL_W-1:0] ctrl_r;
  logic [31:0] stat_w;
  logic wb_req_w;

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction : reg_hit

  assign wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb
  begin
    stat_w = 32'h0000_0000;
    stat_w[`JRC_STAT_CFG] = cfg_mode_r;
    stat_w[`JRC_STAT_DONE] = sync2_r[`JRC_S_DONE];
    stat_w[`JRC_STAT_SYSRST] = ~sync2_r[`JRC_S_SYSRST];
    stat_w[`JRC_STAT_TSTRST] = ~sync2_r[`JRC_S_TSTRST];
    stat_w[`JRC_STAT_DBGREQ] = sync2_r[`JRC_S_DBGREQ];
    stat_w[`JRC_STAT_DEBUG_ACKNOWLEDGE] = debug_acknowledge_o;
    stat_w[`JRC_STAT_RTCKREQ] = ~sync2_r[`JRC_S_RTCKREQ];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req_w;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_r <= `JRC_CTRL_RST;
    else if (wb_req_w && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, `JRC_CTRL_OFS))
      ctrl_r <= wb_dat_i[`JRC_CTRL_W-1:0];
  end

  // Unmapped addresses and writes answer with zero data
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_req_w && !wb_we_i && reg_hit(wb_adr_i, `JRC_CTRL_OFS))
      wb_dat_o <= {{(32 - `JRC_CTRL_W){1'b0}}, ctrl_r};
    else if (wb_req_w && !wb_we_i && reg_hit(wb_adr_i, `JRC_STAT_OFS))
      wb_dat_o <= stat_w;
    else
      wb_dat_o <= 32'h0000_0000;
  end

  // ***********************************
  // Resets, done line and FPGA controls
  // ***********************************
  assign system_reset_n_o = 1'b0;
  assign test_reset_n_o = 1'b0;
  assign global_done_o = 1'b0;

  // Done gating is skipped in config mode, else init would never release
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      system_reset_n_oe_o <= 1'b1;
    else
      system_reset_n_oe_o <= (state_r != jrc_pkg::st_run) || ctrl_r[`JRC_CTRL_SYSRST] ||
                             (!cfg_mode_r && !sync2_r[`JRC_S_DONE]);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      test_reset_n_oe_o <= 1'b1;
    else
      test_reset_n_oe_o <= (state_r == jrc_pkg::st_por) || ctrl_r[`JRC_CTRL_TSTRST];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      global_done_oe_o <= 1'b1;
    else
      global_done_oe_o <= !local_fpga_done_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fpga_init_n_o <= 1'b1;
      fpga_program_n_o <= 1'b1;
    end
    else
    begin
      fpga_init_n_o <= cfg_mode_r ? sync2_r[`JRC_S_SYSRST] : 1'b1;
      fpga_program_n_o <= cfg_mode_r ? sync2_r[`JRC_S_TSTRST] : 1'b1;
    end
  end

  // ***********************************
  // Debug handshake and chain steering
  // ***********************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      core_debug_request_o <= 1'b0;
      debug_acknowledge_o <= 1'b0;
    end
    else
    begin
      core_debug_request_o <= sync2_r[`JRC_S_DBGREQ] || ctrl_r[`JRC_CTRL_DBGREQ];
      debug_acknowledge_o <= core_in_debug_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chip_tap_sel_o <= 1'b1;
      fpgas_in_chain_o <= 1'b0;
      la_connector_en_o <= 1'b1;
      base_fpga_in_cfg_chain_o <= 1'b0;
    end
    else
    begin
      chip_tap_sel_o <= !cfg_mode_r;
      fpgas_in_chain_o <= cfg_mode_r;
      la_connector_en_o <= !cfg_mode_r;
      base_fpga_in_cfg_chain_o <= cfg_mode_r;
    end
  end

  // ***********************************
  // Link clock domain
  // ***********************************
  logic rq_s1_r;
  logic rq_s2_r;
  logic returned_test_clock_en_r;
  logic cfg_t1_r;
  logic cfg_t2_r;

  // Falling-edge update keeps the gate steady while the test clock is high
  always_ff @(negedge tck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rq_s1_r <= 1'b1;
      rq_s2_r <= 1'b1;
      returned_test_clock_en_r <= 1'b0;
    end
    else
    begin
      rq_s1_r <= return_clock_request_n_i;
      rq_s2_r <= rq_s1_r;
      returned_test_clock_en_r <= !rq_s2_r;
    end
  end

  // Clock passed back is the next device's clock in a chain
  assign returned_test_clock_o = tck_i & returned_test_clock_en_r;

  always_ff @(negedge tck_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_t1_r <= 1'b0;
      cfg_t2_r <= 1'b0;
      chain_tdo_o <= 1'b0;
    end
    else
    begin
      cfg_t1_r <= cfg_mode_r;
      cfg_t2_r <= cfg_t1_r;
      chain_tdo_o <= cfg_t2_r ? cfg_chain_tdo_i : dbg_chain_tdo_i;
    end
  end

  // ***********************************
  // Assertions
  // ***********************************
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_wb_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_wb_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req |=> s_wb_ans)
    else $error("bus answer not one cycle");

  a_mode_latched: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == jrc_pkg::st_run |=> $stable(cfg_mode_r))
    else $error("mode changed after power-up");

  a_chain_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == jrc_pkg::st_run && cfg_mode_r |=>
      !la_connector_en_o && base_fpga_in_cfg_chain_o && fpgas_in_chain_o && !chip_tap_sel_o)
    else $error("config mode routing wrong");

  a_debug_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_mode_r |=> la_connector_en_o && !base_fpga_in_cfg_chain_o && chip_tap_sel_o)
    else $error("debug mode routing wrong");

  a_init_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_mode_r |=> fpga_init_n_o == $past(sync2_r[`JRC_S_SYSRST]))
    else $error("init does not follow system reset");

  a_prog_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_mode_r |=> fpga_program_n_o == $past(sync2_r[`JRC_S_TSTRST]))
    else $error("program does not follow test reset");

  a_done_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_mode_r && !sync2_r[`JRC_S_DONE] |=> system_reset_n_oe_o)
    else $error("system reset released before done");

  a_por_treset: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == jrc_pkg::st_por |=> test_reset_n_oe_o)
    else $error("test reset not held at power-up");

  a_dbg_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(core_in_debug_i) |=> debug_acknowledge_o)
    else $error("debug acknowledge missing");

  a_returned_test_clock_low: assert property (@(negedge tck_i) disable iff (rst_i)
    rq_s2_r ##1 1'b1 |-> !returned_test_clock_o)
    else $error("returned clock not held low");

  a_returned_test_clock_pass: assert property (@(negedge tck_i) disable iff (rst_i)
    !rq_s2_r ##1 1'b1 |-> returned_test_clock_o)
    else $error("test clock not returned");

  a_tdo_path: assert property (@(negedge tck_i) disable iff (rst_i)
    !cfg_t2_r |=> chain_tdo_o == $past(dbg_chain_tdo_i))
    else $error("debug chain not on data out");

endmodule : jrc_top

// >>> rtl/jrc_defs.svh
`ifndef JRC_DEFS_SVH
`define JRC_DEFS_SVH

// ***********************************
// Timing
// ***********************************
`define JRC_CLK_MHZ 250
`define JRC_POR_NS 1000
`define JRC_POR_CYC ((`JRC_POR_NS * `JRC_CLK_MHZ + 999) / 1000)
`define JRC_POR_W 9

// ***********************************
// Register offsets and fields
// ***********************************
`define JRC_CTRL_OFS 8'h00
`define JRC_STAT_OFS 8'h04
`define JRC_CTRL_W 3
`define JRC_CTRL_RST 3'h0
`define JRC_CTRL_SYSRST 0
`define JRC_CTRL_TSTRST 1
`define JRC_CTRL_DBGREQ 2
`define JRC_STAT_CFG 0
`define JRC_STAT_DONE 1
`define JRC_STAT_SYSRST 2
`define JRC_STAT_TSTRST 3
`define JRC_STAT_DBGREQ 4
`define JRC_STAT_DEBUG_ACKNOWLEDGE 5
`define JRC_STAT_RTCKREQ 6

// ***********************************
// Pin synchroniser lanes
// ***********************************
`define JRC_NSYNC 6
`define JRC_SYNC_RST 6'h2F
`define JRC_S_CFG 0
`define JRC_S_SYSRST 1
`define JRC_S_TSTRST 2
`define JRC_S_DONE 3
`define JRC_S_DBGREQ 4
`define JRC_S_RTCKREQ 5

`endif

// >>> rtl/jrc_pkg.sv
package jrc_pkg;

  typedef enum logic [1:0] {st_por, st_latch, st_run} jrc_state_t;

endpackage : jrc_pkg

// >>> tb/jrc_equip.sv
// **********
// Equipment test clock source
// **********
module jrc_equip (
  // Control
  input wire logic run_i,
  input wire logic adaptive_i,
  input wire logic returned_test_clock_i,
  // Test clock
  output logic tck_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int k;
  // Stands still outside frames; adaptive mode holds high until the return edge
  initial
  begin
    tck_o = 1'b0;
    // Half-step offset keeps test clock edges off the system clock edges
    #0.5;
    forever
    begin
      if (run_i)
      begin
        #3 tck_o = 1'b1;
        for (k = 0; k < 20 && adaptive_i && returned_test_clock_i !== 1'b1; k++) #0.1;
        #3 tck_o = 1'b0;
      end
      else
        #1;
    end
  end
endmodule : jrc_equip

// >>> tb/testbench.sv
// **********
// Routing and control bench
// **********
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, cyc, stb, we, rq_n, cfg_n, run, eq_s, eq_t, ld, dreq, cind, dt, ct;
  logic returned_test_clock, s_o, s_oe, t_o, t_oe, g_o, g_oe, in_n, pr_n, dack, cdr, tdo, tap, fin, la, bin, tck, ack;
  logic [7:0] adr;
  logic [31:0] dw, dr, q;
  logic [15:0] r;
  int miscompares, checked, i;
  // Open-collector lines with pull-ups
  wire logic s_n = !eq_s && (s_oe ? s_o : 1'b1);
  wire logic t_n = !eq_t && (t_oe ? t_o : 1'b1);
  wire logic g_n = g_oe ? g_o : 1'b1;

  jrc_top i_jrc_top (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .config_mode_select_n_i(cfg_n), .return_clock_request_n_i(rq_n), .returned_test_clock_o(returned_test_clock),
    .system_reset_n_i(s_n), .system_reset_n_o(s_o), .system_reset_n_oe_o(s_oe),
    .test_reset_n_i(t_n), .test_reset_n_o(t_o), .test_reset_n_oe_o(t_oe), .global_done_i(g_n),
    .global_done_o(g_o), .global_done_oe_o(g_oe), .local_fpga_done_i(ld), .fpga_init_n_o(in_n),
    .fpga_program_n_o(pr_n), .debug_request_i(dreq), .debug_acknowledge_o(dack),
    .core_debug_request_o(cdr), .core_in_debug_i(cind), .dbg_chain_tdo_i(dt), .cfg_chain_tdo_i(ct),
    .chain_tdo_o(tdo), .chip_tap_sel_o(tap), .fpgas_in_chain_o(fin), .la_connector_en_o(la),
    .base_fpga_in_cfg_chain_o(bin));
  jrc_equip i_jrc_equip (.run_i(run), .adaptive_i(!rq_n), .returned_test_clock_i(returned_test_clock), .tck_o(tck));

  function logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task test_done;
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cy

  // Master never assumes the answer time; bounded wait instead
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    if (n == 20)
    begin
      miscompares++;
      test_done();
    end
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task tdos(input logic c);
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      r = nx(r);
      dt <= r[0];
      ct <= ~r[0];
      repeat (3) @(negedge tck);
      #1 chk(tdo, r[0] ^ c);
    end
  endtask : tdos

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    test_done();
  end

  initial
  begin
    {rst_i, run, cfg_n, rq_n} = 4'hF;
    {cyc, stb, we, eq_s, eq_t, ld, dreq, cind, dt, ct} = 10'h0;
    adr = 8'h00;
    dw = 32'h0;
    r = 16'h8B7A;
    miscompares = 0;
    checked = 0;
    cy(10);
    rst_i <= 1'b0;
    cy(5);
    chk({t_oe, s_oe}, 2'h3);
    cy(260);
    chk({tap, la, fin, bin, in_n, pr_n, g_oe, s_oe}, 8'hCF);
    ld <= 1'b1;
    cfg_n <= 1'b0;
    eq_s <= 1'b1;
    cy(8);
    chk({s_oe, g_oe, t_oe, tap, fin, in_n}, 6'h05);
    eq_s <= 1'b0;
    for (i = 0; i < 8; i++)
      @(tck) #1 chk(returned_test_clock, 1'b0);
    @(posedge clk_i);
    rq_n <= 1'b0;
    repeat (4) @(negedge tck);
    for (i = 0; i < 16; i++)
      @(tck) #1 chk(returned_test_clock, tck);
    tdos(1'b0);
    @(posedge clk_i);
    dreq <= 1'b1;
    cind <= 1'b1;
    cy(5);
    chk({cdr, dack}, 2'h3);
    dreq <= 1'b0;
    cind <= 1'b0;
    run <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      r = nx(r);
      wb(1'b1, 8'h00, {r, r});
      cy(5);
      chk({s_oe, t_oe, cdr, dack}, {r[0], r[1], r[2], 1'b0});
      wb(1'b0, 8'h04, 32'h0);
      chk(q & 32'h3F, {28'h0, r[1:0], 2'h2});
      wb(1'b0, 8'h00, 32'h0);
      chk(q, {29'h0, r[2:0]});
    end
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, {29'h0, r[2:0]});
    wb(1'b1, 8'h00, 32'h0);
    // Second power-up with the jumper fitted
    run <= 1'b1;
    rst_i <= 1'b1;
    cy(10);
    rst_i <= 1'b0;
    cy(262);
    chk({tap, la, fin, bin}, 4'h3);
    eq_s <= 1'b1;
    eq_t <= 1'b1;
    cy(6);
    chk({in_n, pr_n}, 2'h0);
    wb(1'b0, 8'h04, 32'h0);
    chk(q & 32'hF, 32'hF);
    eq_s <= 1'b0;
    eq_t <= 1'b0;
    cy(6);
    chk({in_n, pr_n}, 2'h3);
    tdos(1'b1);
    test_done();
  end
endmodule : testbench
